//--- hw/elb_ctrl.sv
// enhanced indicator behaviour control: registers, timebase, outputs
`timescale 1ns/1ps
module elb_ctrl #(
  parameter int TICK_CYCLES = elb_pkg::TICK_CYC,
  parameter int PULSE_PERIOD_CYCLES = elb_pkg::PULSE_PERIOD_CYC,
  parameter int PULSE_HIGH_CYCLES = elb_pkg::PULSE_HIGH_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // management register port
  input wire logic ext_page_en,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // software reset and sticky retention
  input wire logic sw_reset,
  input wire logic sticky_retain_en,
  // link status
  input wire logic link_up,
  input wire logic [1:0] speed,
  input wire logic full_duplex,
  input wire logic activity,
  input wire logic collision,
  input wire logic autoneg_fault,
  // simple method drive
  input wire logic [elb_pkg::NUM_OUT-1:0] simple_drive,
  // indicators
  output logic indicator_output_0,
  output logic indicator_output_1,
  output logic indicator_output_2
);
  import elb_pkg::*;

  logic [15:0] indicator_behaviour_control;
  logic [15:0] indicator_mode_select;
  logic wr_behav;
  logic wr_mode;
  logic sticky_clear;
  logic [31:0] tick_cnt;
  logic tick;
  logic [2:0] blink_cnt;
  logic [2:0] blink_len;
  logic blink_phase;
  logic [31:0] pulse_cnt;
  logic pulse_wave;
  logic [1:0] rate;
  logic [NUM_OUT-1:0] shaped;
  logic [NUM_OUT-1:0] hold_act;
  logic [NUM_OUT-1:0] next_out;
  logic [NUM_OUT-1:0] out_q;

  assign wr_behav = reg_wr && ext_page_en && (reg_addr == ADDR_BEHAV);
  assign wr_mode = reg_wr && ext_page_en && (reg_addr == ADDR_MODE_SEL);
  // software reset drops sticky fields only when retention is off
  assign sticky_clear = sw_reset && !sticky_retain_en;
  assign rate = indicator_behaviour_control[RATE_LSB +: 2];

  // behaviour register, sticky: reset wins over a same-cycle write
  always_ff @(posedge clk_sys) begin
    if (srst || sticky_clear) begin
      indicator_behaviour_control <= RST_BEHAV;
    end else if (wr_behav) begin
      indicator_behaviour_control <= reg_wdata & WMASK_BEHAV;
    end
  end

  // mode select register, also sticky
  always_ff @(posedge clk_sys) begin
    if (srst || sticky_clear) begin
      indicator_mode_select <= RST_MODE_SEL;
    end else if (wr_mode) begin
      indicator_mode_select <= reg_wdata & WMASK_MODE_SEL;
    end
  end

  // read data one cycle after the address
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (ext_page_en && reg_addr == ADDR_BEHAV) begin
      reg_rdata <= indicator_behaviour_control;
    end else if (ext_page_en && reg_addr == ADDR_MODE_SEL) begin
      reg_rdata <= indicator_mode_select;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // 25 ms tick, shared by stretch and blink
  always_ff @(posedge clk_sys) begin
    if (srst || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'd1;
    end
  end
  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  // blink phase toggles every 1, 2, 4 or 8 ticks
  assign blink_len = 3'((4'd1 << (2'd3 - rate)) - 4'd1);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end else if (tick) begin
      if (blink_cnt >= blink_len) begin
        blink_cnt <= '0;
        blink_phase <= !blink_phase;
      end else begin
        blink_cnt <= blink_cnt + 3'd1;
      end
    end
  end

  // free-running 5 kHz wave, high for the first fifth
  always_ff @(posedge clk_sys) begin
    if (srst || pulse_cnt == 32'(PULSE_PERIOD_CYCLES - 1)) begin
      pulse_cnt <= '0;
    end else begin
      pulse_cnt <= pulse_cnt + 32'd1;
    end
  end
  assign pulse_wave = (pulse_cnt < 32'(PULSE_HIGH_CYCLES));

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    elb_shaper u_shaper (
      .clk_sys(clk_sys),
      .srst(srst),
      .mode(indicator_mode_select[g*MODE_W +: MODE_W]),
      .stretch_sel(indicator_behaviour_control[STRETCH_LSB + g]),
      .combine_dis(indicator_behaviour_control[COMB_LSB + g]),
      .rate(rate),
      .tick(tick),
      .blink_phase(blink_phase),
      .link_up(link_up),
      .speed(speed),
      .full_duplex(full_duplex),
      .activity(activity),
      .collision(collision),
      .autoneg_fault(autoneg_fault),
      .shaped(shaped[g]),
      .hold_active(hold_act[g])
    );
  end

  // method select; enhanced settings unused in simple method and back
  always_comb begin
    if (indicator_behaviour_control[BIT_METHOD]) begin
      if (indicator_behaviour_control[BIT_PULSE_EN]) begin
        next_out = shaped & {NUM_OUT{pulse_wave}};
      end else begin
        next_out = shaped;
      end
    end else begin
      next_out = simple_drive;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_q <= '0;
    end else begin
      out_q <= next_out;
    end
  end
  assign indicator_output_0 = out_q[0];
  assign indicator_output_1 = out_q[1];
  assign indicator_output_2 = out_q[2];

  // checks
  AST_RESET_VALUE: assert property (@(posedge clk_sys)
    srst |=> indicator_behaviour_control == RST_BEHAV)
    else $error("behaviour register not at reset value");

  AST_RESERVED_ZERO: assert property (@(posedge clk_sys)
    disable iff (srst)
    (indicator_behaviour_control & ~WMASK_BEHAV) == 16'h0000)
    else $error("reserved behaviour bits not zero");

  AST_WRITE_TAKEN: assert property (@(posedge clk_sys)
    disable iff (srst)
    wr_behav && !sticky_clear
    |=> indicator_behaviour_control == ($past(reg_wdata) & WMASK_BEHAV))
    else $error("behaviour write not stored");

  AST_STICKY_KEEP: assert property (@(posedge clk_sys)
    disable iff (srst)
    sw_reset && sticky_retain_en && !wr_behav
    |=> $stable(indicator_behaviour_control))
    else $error("sticky field lost on software reset");

  AST_STICKY_CLEAR: assert property (@(posedge clk_sys)
    disable iff (srst)
    sticky_clear |=> indicator_behaviour_control == RST_BEHAV)
    else $error("sticky field kept with retention off");

  AST_SIMPLE_METHOD: assert property (@(posedge clk_sys)
    disable iff (srst)
    !indicator_behaviour_control[BIT_METHOD]
    |=> {indicator_output_2, indicator_output_1, indicator_output_0}
      == $past(simple_drive))
    else $error("simple method not followed");

  AST_PULSE_GATE: assert property (@(posedge clk_sys)
    disable iff (srst)
    indicator_behaviour_control[BIT_METHOD]
    && indicator_behaviour_control[BIT_PULSE_EN] && !pulse_wave
    |=> !indicator_output_0 && !indicator_output_1 && !indicator_output_2)
    else $error("output high outside pulse window");

  AST_PULSE_DUTY: assert property (@(posedge clk_sys)
    disable iff (srst)
    pulse_cnt == 32'd0 |-> pulse_wave [*8])
    else $error("pulse window too short");

  AST_FORCE_ON: assert property (@(posedge clk_sys)
    disable iff (srst)
    indicator_behaviour_control[BIT_METHOD]
    && !indicator_behaviour_control[BIT_PULSE_EN]
    && indicator_mode_select[3:0] == MODE_FORCE_ON
    |=> indicator_output_0)
    else $error("forced-on output is off");

  AST_STRETCH_HOLD: assert property (@(posedge clk_sys)
    disable iff (srst)
    activity && indicator_mode_select[3:0] == MODE_ACT
    |=> hold_act[0] [*8])
    else $error("stretch ended early");

  AST_COMBINE_OFF: assert property (@(posedge clk_sys)
    disable iff (srst)
    indicator_behaviour_control[BIT_METHOD]
    && !indicator_behaviour_control[BIT_PULSE_EN]
    && indicator_behaviour_control[COMB_LSB]
    && indicator_mode_select[3:0] == MODE_LINK_ACT
    |=> indicator_output_0 == $past(link_up))
    else $error("combine disable not showing link only");

  AST_BLINK_STEP: assert property (@(posedge clk_sys)
    disable iff (srst)
    blink_phase != $past(blink_phase) |-> $past(tick))
    else $error("blink phase moved without a tick");

  COV_ENHANCED: cover property (@(posedge clk_sys)
    wr_behav && reg_wdata[BIT_METHOD]);
  COV_PULSING: cover property (@(posedge clk_sys)
    indicator_behaviour_control[BIT_PULSE_EN] && indicator_output_0);
  COV_STICKY_RESET: cover property (@(posedge clk_sys) sticky_clear);
  COV_BLINK: cover property (@(posedge clk_sys)
    tick && hold_act[1] && !indicator_behaviour_control[STRETCH_LSB + 1]);
endmodule

//--- hw/elb_pkg.sv
// constants for the enhanced indicator behaviour control block
// Overview of operation
// - pulsing bit set chops every active output with 5 kHz, 20% duty wave
// - rate field 11:10 sets shared blink rate or stretch time
// - rate field resets to 01, giving 5 Hz blink, 200 ms stretch
// - bits 7:5 pick stretch (1) or blink (0) per output; reset 1
// - bit 4 picks enhanced method (1) or simple method (0); reset 0
// - inactive method's settings are ignored while the other is chosen
// - bits 2:0 disable combined link/activity, duplex/collision views; reset 0
// - all writable behaviour fields are sticky
// - sticky fields survive software reset when retention is on, else default
// - each output has a four-bit mode selector with sixteen codes
package elb_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int NUM_OUT = 3;

  // register addresses with the extended page selected
  localparam logic [4:0] ADDR_MODE_SEL = 5'h10;
  localparam logic [4:0] ADDR_BEHAV = 5'h11;

  // behaviour register fields
  localparam int BIT_PULSE_EN = 12;
  localparam int RATE_LSB = 10;
  localparam int STRETCH_LSB = 5;
  localparam int BIT_METHOD = 4;
  localparam int COMB_LSB = 0;
  localparam int MODE_W = 4;

  // reset values and writable masks
  localparam logic [15:0] RST_BEHAV = 16'h04E0;
  localparam logic [15:0] WMASK_BEHAV = 16'h1CF7;
  localparam logic [15:0] RST_MODE_SEL = 16'h021A;
  localparam logic [15:0] WMASK_MODE_SEL = 16'h0FFF;

  // indicator mode codes
  localparam logic [3:0] MODE_LINK_ACT = 4'h0;
  localparam logic [3:0] MODE_L1000_ACT = 4'h1;
  localparam logic [3:0] MODE_L100_ACT = 4'h2;
  localparam logic [3:0] MODE_L10_ACT = 4'h3;
  localparam logic [3:0] MODE_L100_1000 = 4'h4;
  localparam logic [3:0] MODE_L10_1000 = 4'h5;
  localparam logic [3:0] MODE_L10_100 = 4'h6;
  localparam logic [3:0] MODE_DPX_COL = 4'h8;
  localparam logic [3:0] MODE_COL = 4'h9;
  localparam logic [3:0] MODE_ACT = 4'hA;
  localparam logic [3:0] MODE_ANEG_FAULT = 4'hC;
  localparam logic [3:0] MODE_FORCE_OFF = 4'hE;
  localparam logic [3:0] MODE_FORCE_ON = 4'hF;

  // link speed codes
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // pulsing waveform
  localparam int PULSE_FREQ_HZ = 5000;
  localparam int PULSE_DUTY_PCT = 20;
  localparam int PULSE_PERIOD_CYC = CLK_HZ / PULSE_FREQ_HZ;
  localparam int PULSE_HIGH_CYC = PULSE_PERIOD_CYC * PULSE_DUTY_PCT / 100;

  // timebase tick: half period of the fastest (20 Hz) blink
  localparam int TICK_MS = 25;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // shortest stretch (rate 11), 50 ms, in ticks
  localparam int STRETCH_MS_MIN = 50;
  localparam logic [4:0] STRETCH_TICKS_MIN = 5'(STRETCH_MS_MIN / TICK_MS);
  localparam int HOLD_W = 5;
endpackage

//--- hw/elb_shaper.sv
// per-output indication decode, stretch and blink shaping
`timescale 1ns/1ps
module elb_shaper (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // settings
  input wire logic [elb_pkg::MODE_W-1:0] mode,
  input wire logic stretch_sel,
  input wire logic combine_dis,
  input wire logic [1:0] rate,
  // shared timing
  input wire logic tick,
  input wire logic blink_phase,
  // link status
  input wire logic link_up,
  input wire logic [1:0] speed,
  input wire logic full_duplex,
  input wire logic activity,
  input wire logic collision,
  input wire logic autoneg_fault,
  // shaped level
  output logic shaped,
  output logic hold_active
);
  import elb_pkg::*;

  logic [HOLD_W-1:0] hold;
  logic [HOLD_W-1:0] load;
  logic col_mode;
  logic evt;
  logic link_ok;
  logic evt_view;

  assign col_mode = (mode == MODE_DPX_COL) || (mode == MODE_COL);
  assign evt = col_mode ? collision : activity;
  // one extra tick covers the partial tick at the event
  assign load = HOLD_W'((STRETCH_TICKS_MIN << (2'd3 - rate)) + 5'd1);
  assign hold_active = (hold != '0);

  // restart on every event, count down on ticks
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hold <= '0;
    end else if (evt) begin
      hold <= load;
    end else if (tick && hold_active) begin
      hold <= hold - 5'd1;
    end
  end

  // stretch shows solid, blink shows the shared phase
  assign evt_view = hold_active && (stretch_sel || blink_phase);

  always_comb begin
    unique case (mode)
      MODE_LINK_ACT: link_ok = link_up;
      MODE_L1000_ACT: link_ok = link_up && (speed == SPEED_1000);
      MODE_L100_ACT: link_ok = link_up && (speed == SPEED_100);
      MODE_L10_ACT: link_ok = link_up && (speed == SPEED_10);
      MODE_L100_1000: link_ok = link_up && (speed != SPEED_10);
      MODE_L10_1000: link_ok = link_up && (speed != SPEED_100);
      MODE_L10_100: link_ok = link_up && (speed != SPEED_1000);
      MODE_DPX_COL: link_ok = full_duplex;
      default: link_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (mode)
      MODE_COL, MODE_ACT: shaped = evt_view;
      MODE_ANEG_FAULT: shaped = autoneg_fault;
      MODE_FORCE_OFF: shaped = 1'b0;
      MODE_FORCE_ON: shaped = 1'b1;
      4'h7, 4'hB, 4'hD: shaped = 1'b0;
      // combined view: steady state, events dim it for the stretch or blink it
      default: shaped = link_ok &&
        (combine_dis || !hold_active || (!stretch_sel && blink_phase));
    endcase
  end
endmodule

//--- test/elb_led_panel.sv
// panel model: counts lit cycles of the indicators and level changes of output 0
`timescale 1ns/1ps
module elb_led_panel (
  // clock and counter clear
  input wire logic clk_sys,
  input wire logic clr,
  // indicator levels
  input wire logic [2:0] led,
  // observed counts
  output logic [15:0] lit0,
  output logic [15:0] lit1,
  output logic [15:0] lit2,
  output logic [15:0] tog0
);
  logic last0;
  // a lamp only shows the pin level; it keeps no state of its own
  always_ff @(posedge clk_sys) begin
    last0 <= led[0];
    if (clr) begin
      lit0 <= 16'h0000;
      lit1 <= 16'h0000;
      lit2 <= 16'h0000;
      tog0 <= 16'h0000;
    end else begin
      lit0 <= lit0 + 16'(led[0]);
      lit1 <= lit1 + 16'(led[1]);
      lit2 <= lit2 + 16'(led[2]);
      tog0 <= tog0 + 16'(led[0] != last0);
    end
  end
endmodule

//--- test/elb_ctrl_bench.sv
// self-checking bench for the indicator behaviour control block
`timescale 1ns/1ps
module elb_ctrl_bench;
  import elb_pkg::*;
  // short tick keeps stretch and blink times within a few hundred cycles
  localparam int TK = 10;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ext_page_en = 1'b1;
  logic reg_wr = 1'b0;
  logic [4:0] reg_addr = 5'h11;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, d, lit0, lit1, lit2, tog0;
  logic sw_reset = 1'b0;
  logic sticky_retain_en = 1'b1;
  logic link_up = 1'b0;
  logic full_duplex = 1'b0;
  logic activity = 1'b0;
  logic collision = 1'b0;
  logic autoneg_fault = 1'b0;
  logic [1:0] speed = 2'h2;
  logic [2:0] simple_drive = 3'h0;
  logic [2:0] leds;
  logic clr = 1'b1;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int hs;
  logic [15:0] m;
  logic [2:0] e;
  integer seed = 32'hB4C4ECFB;

  elb_ctrl #(.TICK_CYCLES(TK), .PULSE_PERIOD_CYCLES(40),
    .PULSE_HIGH_CYCLES(8)) dut (.clk_sys(clk_sys), .srst(srst),
    .ext_page_en(ext_page_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sw_reset(sw_reset),
    .sticky_retain_en(sticky_retain_en), .link_up(link_up),
    .speed(speed), .full_duplex(full_duplex), .activity(activity),
    .collision(collision), .autoneg_fault(autoneg_fault),
    .simple_drive(simple_drive), .indicator_output_0(leds[0]),
    .indicator_output_1(leds[1]), .indicator_output_2(leds[2]));
  elb_led_panel panel (.clk_sys(clk_sys), .clr(clr), .led(leds),
    .lit0(lit0), .lit1(lit1), .lit2(lit2), .tog0(tog0));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic complete_run;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // generous ceiling: the full sequence needs roughly 4300 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic cmp16(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_rng(input string what, input int lo, hi,
                         input logic [15:0] got);
    samples_checked++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      error_cnt++;
      $display("ERROR %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask
  // steady level of one output: no events, combining disabled
  function automatic logic exp_level(input logic [3:0] md, input logic up,
                                     input logic [1:0] sp, input logic fdx,
                                     input logic flt);
    case (md)
      4'h0: return up;
      4'h1: return up && sp == 2'h2;
      4'h2: return up && sp == 2'h1;
      4'h3: return up && sp == 2'h0;
      4'h4: return up && (sp == 2'h1 || sp == 2'h2);
      4'h5: return up && (sp == 2'h0 || sp == 2'h2);
      4'h6: return up && (sp == 2'h0 || sp == 2'h1);
      4'h8: return fdx;
      4'hC: return flt;
      4'hF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
  task automatic soft_reset(input logic keep);
    @(negedge clk_sys);
    sticky_retain_en = keep;
    sw_reset = 1'b1;
    @(negedge clk_sys);
    sw_reset = 1'b0;
    sticky_retain_en = 1'b1;
  endtask
  // clears the panel counts, optionally fires one event, then waits
  task automatic watch(input int n, input logic pulse);
    @(negedge clk_sys);
    clr = 1'b1;
    @(negedge clk_sys);
    clr = 1'b0;
    if (pulse) activity = 1'b1;
    @(negedge clk_sys);
    if (pulse) activity = 1'b0;
    repeat (n - 1) @(negedge clk_sys);
  endtask

  initial begin
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    rd(5'h11, d);
    cmp16("behav reset", 16'h04E0, d);
    rd(5'h10, d);
    cmp16("mode reset", 16'h021A, d);
    for (int i = 0; i < 6; i++) begin
      wr(5'h11, 16'($random(seed)));
      rd(5'h11, d);
      cmp16("behav rw", reg_wdata & 16'h1CF7, d);
    end
    wr(5'h11, 16'hFFFF);
    rd(5'h11, d);
    cmp16("behav ones", 16'h1CF7, d);
    ext_page_en = 1'b0;
    wr(5'h11, 16'h0000);
    ext_page_en = 1'b1;
    rd(5'h11, d);
    cmp16("page off write", 16'h1CF7, d);
    rd(5'h12, d);
    cmp16("unmapped read", 16'h0000, d);
    soft_reset(1'b1);
    rd(5'h11, d);
    cmp16("sticky kept", 16'h1CF7, d);
    wr(5'h10, 16'h0FFF);
    soft_reset(1'b0);
    rd(5'h11, d);
    cmp16("sticky cleared", 16'h04E0, d);
    rd(5'h10, d);
    cmp16("mode cleared", 16'h021A, d);
    // simple method: enhanced force-on settings must not show
    wr(5'h10, 16'h0FFF);
    wr(5'h11, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      simple_drive = 3'($random(seed));
      repeat (3) @(negedge clk_sys);
      cmp16("simple", 16'(simple_drive), 16'(leds));
    end
    wr(5'h10, 16'h0EEE);
    wr(5'h11, 16'h0010);
    repeat (3) @(negedge clk_sys);
    cmp16("forced off", 16'h0000, 16'(leds));
    wr(5'h10, 16'h0FFF);
    watch(400, 1'b0);
    cmp_rng("steady on", 400, 403, lit1);
    wr(5'h11, 16'h1010);
    watch(400, 1'b0);
    cmp_rng("pulsed 0", 80, 82, lit0);
    cmp_rng("pulsed 2", 80, 82, lit2);
    wr(5'h10, 16'h0AAA);
    for (int r = 0; r < 4; r++) begin
      hs = 2 << (3 - r);
      wr(5'h11, 16'h00F0 | (16'(r) << 10));
      watch(200, 1'b1);
      cmp_rng("stretch 0", hs * TK, (hs + 1) * TK + 3, lit0);
      cmp_rng("stretch 2", hs * TK, (hs + 1) * TK + 3, lit2);
      wr(5'h11, 16'h00D0 | (16'(r) << 10));
      activity = 1'b1;
      hs = TK << (3 - r);
      // let the output settle so the window sees no start-up edge
      repeat (2) @(negedge clk_sys);
      watch(200, 1'b0);
      cmp_rng("blink toggles", 200 / hs - 1, 200 / hs + 1, tog0);
      cmp_rng("stretch held", 200, 203, lit1);
      activity = 1'b0;
      repeat (200) @(negedge clk_sys);
    end
    // link with activity: combined view goes dark for the stretch
    wr(5'h10, 16'h0000);
    link_up = 1'b1;
    wr(5'h11, 16'h04F0);
    watch(200, 1'b1);
    cmp_rng("combined", 200 - 103, 200 - 80 + 3, lit0);
    wr(5'h11, 16'h04F7);
    watch(200, 1'b1);
    cmp_rng("link only", 200, 203, lit0);
    // collision only, duplex/collision and link/activity side by side
    wr(5'h10, 16'h0089);
    wr(5'h11, 16'h04F0);
    full_duplex = 1'b1;
    collision = 1'b1;
    watch(200, 1'b0);
    cmp_rng("collision held", 200, 203, lit0);
    cmp_rng("duplex dimmed", 0, 0, lit1);
    cmp_rng("link steady", 200, 203, lit2);
    collision = 1'b0;
    repeat (200) @(negedge clk_sys);
    // random mode codes with random link status, link or duplex only
    wr(5'h11, 16'h04F7);
    for (int i = 0; i < 24; i++) begin
      m = 16'($random(seed)) & 16'h0FFF;
      wr(5'h10, m);
      link_up = 1'($random(seed));
      full_duplex = 1'($random(seed));
      autoneg_fault = 1'($random(seed));
      speed = 2'($random(seed));
      if (speed == 2'h3) begin
        speed = 2'h2;
      end
      repeat (3) @(negedge clk_sys);
      for (int g = 0; g < 3; g++) begin
        e[g] = exp_level(m[4*g +: 4], link_up, speed, full_duplex,
                         autoneg_fault);
      end
      cmp16("mode view", 16'(e), 16'(leds));
    end
    complete_run();
  end
endmodule
